/* hdl/dap_conv.sv */
// Serial interface and power state control of a dual 12-bit converter
`timescale 1ns/1ns
`default_nettype none
module dap_conv
	import dap_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         cs_n_pin,
	input  wire logic         conv_serial_clock,
	input  wire dap_result_t  result_in,
	output var  dap_dout_t    dout,
	output var  logic         hold,
	output var  logic         conv_busy,
	output var  dap_pwr_t     pwr_state,
	output var  logic         ref_on,
	output var  logic         analog_on,
	output var  logic         powered_up
);
	logic        rst_a;
	logic        rst_n;
	logic        cs_act_pin;
	logic        cs_act;
	logic        cs_n;
	logic        sck;
	logic        cs_n_d;
	logic        sck_d;
	logic        cs_fall;
	logic        cs_rise;
	logic        sck_fall;
	logic        sck_rise;

	dap_result_t shadow;
	logic [5:0]  falls;
	logic        wake;
	logic [15:0] pu_cnt;
	dap_result_t next_shadow;
	logic [5:0]  next_falls;
	dap_pwr_t    next_pwr;
	logic        next_wake;
	logic [15:0] next_pu_cnt;
	logic        next_hold;
	logic        next_busy;
	dap_dout_t   next_dout;
	logic        next_ref;
	logic        next_analog;
	logic        next_ready;

	localparam int WAKE_DLY = PWRUP_CYC;

	// Bit shown on a line for a given count of falls: two zeros, 12 bits,
	// two zeros, then the other channel in the same shape.
	function automatic logic bit_at(input logic [5:0] n,
		input logic [RES_W-1:0] first, input logic [RES_W-1:0] second);
		logic [5:0] k;
		logic [5:0] p;
		k = (n >= EDGE_FIRST_END) ? n - EDGE_FIRST_END : n;
		p = k - 6'(LEAD_ZEROS);
		if (k < 6'(LEAD_ZEROS) || p >= 6'(RES_W))
			bit_at = 1'b0;
		else if (n >= EDGE_FIRST_END)
			bit_at = second[RES_W-1-int'(p)];
		else
			bit_at = first[RES_W-1-int'(p)];
	endfunction

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_a <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a <= 1'b1;
			rst_n <= rst_a;
		end
	end

	// Select is filtered as an active-high copy so that the filter's reset
	// level reads as deselected and no false frame starts after reset.
	always_comb begin
		cs_act_pin = ~cs_n_pin;
		cs_n       = ~cs_act;
	end

	dap_sync u_cs (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (cs_act_pin),
		.level (cs_act)
	);

	dap_sync u_sck (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (conv_serial_clock),
		.level (sck)
	);

	// Edge detectors look only at filtered levels
	always_comb begin
		cs_fall  = cs_n_d & ~cs_n;
		cs_rise  = ~cs_n_d & cs_n;
		sck_fall = sck_d & ~sck & ~cs_n & ~cs_fall;
		sck_rise = ~sck_d & sck & ~cs_n;
	end

	always_comb begin
		next_shadow = shadow;
		next_falls  = falls;
		next_pwr    = pwr_state;
		next_wake   = wake;
		next_pu_cnt = pu_cnt;
		next_hold   = hold;
		next_busy   = conv_busy;
		next_dout   = dout;
		if (pu_cnt != 16'h0000)
			next_pu_cnt = pu_cnt - 16'h0001;
		if (cs_fall) begin
			next_falls  = 6'h00;
			next_shadow = result_in;
			next_hold   = 1'b1;
			next_busy   = 1'b1;
			next_dout   = '{1'b0, 1'b1, 1'b0, 1'b1};
			next_wake   = (pwr_state != DAP_NORMAL);
		end else if (cs_rise) begin
			next_busy = 1'b0;
			next_hold = 1'b0;
			next_dout = '{1'b0, 1'b0, 1'b0, 1'b0};
			next_wake = 1'b0;
			if (falls >= EDGE_PD_LO && falls < EDGE_PD_HI) begin
				if (pwr_state == DAP_NORMAL)
					next_pwr = DAP_PARTIAL;
				else
					next_pwr = DAP_FULL;
			end else if (falls >= EDGE_PD_HI && wake) begin
				next_pwr    = DAP_NORMAL;
				next_pu_cnt = 16'(PWRUP_CYC);
			end
			// Fewer than two falls leaves the state alone
		end else if (sck_fall) begin
			if (falls != EDGE_MAX)
				next_falls = falls + 6'h01;
			if (falls + 6'h01 >= EDGE_CHAIN_END) begin
				next_dout = '{1'b0, 1'b0, 1'b0, 1'b0};
			end else if (conv_busy) begin
				next_dout.out_a = bit_at(falls + 6'h01,
					shadow.chan_a, shadow.chan_b);
				next_dout.out_b = bit_at(falls + 6'h01,
					shadow.chan_b, shadow.chan_a);
			end
		end else if (sck_rise && falls == EDGE_TRACK) begin
			next_hold = 1'b0;
		end
		// Reference stays up in partial; powering while waking
		next_ref    = (next_pwr != DAP_FULL) | next_wake;
		next_analog = (next_pwr == DAP_NORMAL) | next_wake;
		next_ready  = (next_pwr == DAP_NORMAL) &&
			(next_pu_cnt == 16'h0000);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_n_d     <= 1'b1;
			sck_d      <= 1'b0;
			shadow     <= '0;
			falls      <= 6'h00;
			pwr_state  <= DAP_NORMAL;
			wake       <= 1'b0;
			pu_cnt     <= 16'h0000;
			hold       <= 1'b0;
			conv_busy  <= 1'b0;
			dout       <= '0;
			ref_on     <= 1'b1;
			analog_on  <= 1'b1;
			powered_up <= 1'b1;
		end else begin
			cs_n_d     <= cs_n;
			sck_d      <= sck;
			shadow     <= next_shadow;
			falls      <= next_falls;
			pwr_state  <= next_pwr;
			wake       <= next_wake;
			pu_cnt     <= next_pu_cnt;
			hold       <= next_hold;
			conv_busy  <= next_busy;
			dout       <= next_dout;
			ref_on     <= next_ref;
			analog_on  <= next_analog;
			powered_up <= next_ready;
		end
	end

	chk_enter_partial: assert property (@(posedge clk) disable iff (!rst_n)
		(cs_rise && pwr_state == DAP_NORMAL && falls >= EDGE_PD_LO &&
		falls < EDGE_PD_HI) |=> pwr_state == DAP_PARTIAL)
		else $error("partial power-down not entered");
	chk_glitch_keep: assert property (@(posedge clk) disable iff (!rst_n)
		(cs_rise && falls < EDGE_PD_LO) |=> $stable(pwr_state))
		else $error("power state changed on short frame");
	chk_enter_full: assert property (@(posedge clk) disable iff (!rst_n)
		(cs_rise && pwr_state == DAP_PARTIAL && falls >= EDGE_PD_LO &&
		falls < EDGE_PD_HI) |=> pwr_state == DAP_FULL)
		else $error("full power-down not entered");
	chk_tri_on_rise: assert property (@(posedge clk) disable iff (!rst_n)
		cs_rise |=> !dout.oe_a && !dout.oe_b && !conv_busy)
		else $error("outputs not released on select rise");
	chk_drive_on_fall: assert property (@(posedge clk) disable iff (!rst_n)
		cs_fall |=> dout.oe_a && dout.oe_b && hold && !dout.out_a)
		else $error("frame start not handled");
	chk_chain_end: assert property (@(posedge clk) disable iff (!rst_n)
		(sck_fall && falls == EDGE_CHAIN_END - 6'h01) |=> !dout.oe_a)
		else $error("line not released at 32nd fall");
	chk_track: assert property (@(posedge clk) disable iff (!rst_n)
		(sck_rise && !cs_fall && !cs_rise && falls == EDGE_TRACK)
		|=> !hold)
		else $error("sampler not back to track");
	chk_wake_time: assert property (@(posedge clk) disable iff (!rst_n)
		(cs_rise && wake && falls >= EDGE_PD_HI) |=> !powered_up ##WAKE_DLY
		powered_up)
		else $error("power-up time wrong");
	cov_partial: cover property (@(posedge clk) disable iff (!rst_n)
		pwr_state == DAP_PARTIAL);
	cov_full: cover property (@(posedge clk) disable iff (!rst_n)
		pwr_state == DAP_FULL);
	cov_chain: cover property (@(posedge clk) disable iff (!rst_n)
		sck_fall && falls == EDGE_CHAIN_END - 6'h01);
endmodule
`default_nettype wire

/* hdl/dap_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
`default_nettype none
module dap_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output var  logic level
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;

	// Only s2 reads s1; a change counts once s2 and s3 agree
	always_comb begin
		next_level = (s2 == s3) ? s3 : level;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1    <= 1'b0;
			s2    <= 1'b0;
			s3    <= 1'b0;
			level <= 1'b0;
		end else begin
			s1    <= pin;
			s2    <= s1;
			s3    <= s2;
			level <= next_level;
		end
	end
endmodule
`default_nettype wire

/* inc/dap_pkg.sv */
// Package for the dual converter serial control block
package dap_pkg;
	localparam int unsigned CLK_MHZ        = 50;
	localparam int unsigned PWRUP_NS       = 1000;
	localparam int unsigned PWRUP_CYC      = (PWRUP_NS * CLK_MHZ) / 1000;
	localparam logic [5:0]  EDGE_PD_LO     = 6'h02;
	localparam logic [5:0]  EDGE_PD_HI     = 6'h0A;
	localparam logic [5:0]  EDGE_TRACK     = 6'h0D;
	localparam logic [5:0]  EDGE_FIRST_END = 6'h10;
	localparam logic [5:0]  EDGE_CHAIN_END = 6'h20;
	localparam logic [5:0]  EDGE_MAX       = 6'h3F;
	localparam int unsigned RES_W          = 12;
	localparam logic [3:0]  LEAD_ZEROS     = 4'h2;

	typedef enum logic [1:0] {
		DAP_NORMAL  = 2'b00,
		DAP_PARTIAL = 2'b01,
		DAP_FULL    = 2'b11
	} dap_pwr_t;

	typedef struct packed {
		logic [RES_W-1:0] chan_a;
		logic [RES_W-1:0] chan_b;
	} dap_result_t;

	typedef struct packed {
		logic out_a;
		logic oe_a;
		logic out_b;
		logic oe_b;
	} dap_dout_t;
endpackage

/* verification/dap_conv_tb.sv */
// Testbench for the dual converter serial control block
`timescale 1ns/1ns
`default_nettype none
module dap_conv_tb;
	import dap_pkg::*;
	typedef struct {
		int       nf;
		dap_pwr_t pwr;
		logic     oe;
		logic     hold;
		logic     dc;
		int       gap;
	} dap_row_t;
	logic        clk;
	logic        nrst;
	logic        cs_n_pin;
	logic        sclk;
	dap_result_t result_in;
	dap_dout_t   dout;
	logic        hold, busy, ref_on, analog_on, powered_up;
	dap_pwr_t    pwr_state;
	int          mismatches = 0;
	int          check_count = 0;
	logic [31:0] ca, cb, full;
	dap_row_t    rows[14] = '{'{14, DAP_NORMAL, 1, 0, 1, 0},
		'{1, DAP_NORMAL, 1, 1, 1, 0}, '{16, DAP_NORMAL, 1, 0, 1, 0},
		'{32, DAP_NORMAL, 0, 0, 1, 0}, '{12, DAP_NORMAL, 1, 1, 1, 0},
		'{13, DAP_NORMAL, 1, 0, 1, 0}, '{3, DAP_PARTIAL, 0, 0, 0, 0},
		'{1, DAP_PARTIAL, 0, 0, 0, 0}, '{9, DAP_FULL, 0, 0, 0, 0},
		'{5, DAP_FULL, 0, 0, 0, 0}, '{10, DAP_NORMAL, 0, 0, 0, PWRUP_CYC},
		'{2, DAP_PARTIAL, 0, 0, 0, 0}, '{9, DAP_FULL, 0, 0, 0, 0},
		'{14, DAP_NORMAL, 0, 0, 0, 0}};

	dap_conv dut (.clk(clk), .nrst(nrst), .cs_n_pin(cs_n_pin),
		.conv_serial_clock(sclk), .result_in(result_in), .dout(dout),
		.hold(hold), .conv_busy(busy), .pwr_state(pwr_state),
		.ref_on(ref_on), .analog_on(analog_on), .powered_up(powered_up));
	dap_host host (.clk(clk), .dout(dout), .cs_n_pin(cs_n_pin),
		.conv_serial_clock(sclk));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic reset_dut();
		nrst = 1'b0;
		repeat (12) @(posedge clk);
		chk("rst dout", 32'h0, 32'(dout));
		chk("rst power", 32'(DAP_NORMAL), 32'(pwr_state));
		#1 nrst = 1'b1;
		repeat (12) @(posedge clk);
		#1;
	endtask

	task automatic run_row(input dap_row_t r);
		host.frame(r.nf, ca, cb);
		full = {2'b00, result_in.chan_a, 4'h0, result_in.chan_b, 2'b00};
		if (r.dc) begin
			chk("line a", full >> (32 - r.nf), ca);
			full = {2'b00, result_in.chan_b, 4'h0, result_in.chan_a, 2'b00};
			chk("line b", full >> (32 - r.nf), cb);
			chk("oe a", 32'(r.oe), 32'(dout.oe_a));
			chk("hold", 32'(r.hold), 32'(hold));
		end
		host.release_sel();
		chk("oe off", 32'h0, 32'({dout.oe_a, dout.oe_b, busy}));
		chk("power", 32'(r.pwr), 32'(pwr_state));
		chk("ref", 32'(r.pwr != DAP_FULL), 32'(ref_on));
		chk("analog", 32'(r.pwr == DAP_NORMAL), 32'(analog_on));
		// Host waits out the power-up time before its next frame
		if (r.gap > 0) begin
			chk("not woken", 32'h0, 32'(powered_up));
			repeat (r.gap) @(posedge clk);
			#1;
			chk("woken", 32'h1, 32'(powered_up));
		end
	endtask

	// Watchdog sized well above the longest expected run
	initial begin
		#500_000;
		mismatches++;
		results();
	end

	initial begin
		result_in = '0;
		reset_dut();
		$display("test reset done");
		foreach (rows[i]) begin
			result_in.chan_a = 12'hA5C ^ 12'(i);
			result_in.chan_b = 12'h3B1 + 12'(i);
			run_row(rows[i]);
			$display("row %0d done", i);
		end
		// Last row woke from full power-down; the wait is the host's job
		chk("not ready", 32'h0, 32'(powered_up));
		repeat (PWRUP_CYC) @(posedge clk);
		#1;
		chk("ready", 32'h1, 32'(powered_up));
		$display("test power up done");
		// Reset in mid-frame must leave normal mode and idle lines
		host.frame(4, ca, cb);
		reset_dut();
		host.release_sel();
		chk("power", 32'(DAP_NORMAL), 32'(pwr_state));
		$display("test mid reset done");
		results();
	end
endmodule
`default_nettype wire

/* verification/dap_host.sv */
// Host serial port model driving select and the serial clock
`timescale 1ns/1ns
`default_nettype none
module dap_host
	import dap_pkg::*;
(
	input  wire logic      clk,
	input  wire dap_dout_t dout,
	output var  logic      cs_n_pin,
	output var  logic      conv_serial_clock
);
	// Serial clock idles high so the first edge in a frame is a fall
	initial begin
		cs_n_pin = 1'b1;
		conv_serial_clock = 1'b1;
	end
	// Samples late in the high phase; a released line reads back as z
	task automatic frame(input int nf, output logic [31:0] ca,
		output logic [31:0] cb);
		ca = '0;
		cb = '0;
		@(posedge clk);
		#1 cs_n_pin = 1'b0;
		repeat (8) @(posedge clk);
		for (int i = 0; i < nf; i++) begin
			#1 ca = {ca[30:0], dout.oe_a ? dout.out_a : 1'bz};
			cb = {cb[30:0], dout.oe_b ? dout.out_b : 1'bz};
			conv_serial_clock = 1'b0;
			repeat (4) @(posedge clk);
			#1 conv_serial_clock = 1'b1;
			repeat (4) @(posedge clk);
		end
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic release_sel();
		cs_n_pin = 1'b1;
		repeat (10) @(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire
